// >>> interrupt_flag_enable_bank.sv
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
module interrupt_flag_enable_bank (
  input wire logic sys_clk, // 200 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write when high
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lane selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // one-cycle acknowledge
  input wire logic can1_rx_ready_evt, // can 1 receive ready
  input wire logic serial_periph2_event_evt, // spi 2 event
  input wire logic serial_periph2_error_evt, // spi 2 error
  input wire logic pwm_fault_a_evt, // pwm fault a
  input wire logic dma_ch5_done_evt, // dma 5 complete
  input wire logic converter_iface_event_evt, // converter iface event
  input wire logic converter_iface_error_evt, // converter iface error
  input wire logic quad_encoder_event_evt, // encoder event
  input wire logic pwm_error_evt, // pwm error
  input wire logic can2_event_evt, // can 2 event
  input wire logic can2_rx_ready_evt, // can 2 receive ready
  input wire logic ext_pin4_evt, // external pin 4
  input wire logic ext_pin3_evt, // external pin 3
  input wire logic timer_nine_evt, // timer 9
  input wire logic timer_eight_evt, // timer 8
  input wire logic i2c_two_master_evt, // i2c 2 master
  input wire logic i2c_two_slave_evt, // i2c 2 slave
  input wire logic timer_seven_evt, // timer 7
  input wire logic can2_tx_request_evt, // can 2 transmit request
  input wire logic can1_tx_request_evt, // can 1 transmit request
  input wire logic dma_ch7_done_evt, // dma 7 complete
  input wire logic dma_ch6_done_evt, // dma 6 complete
  input wire logic uart_two_error_evt, // uart 2 error
  input wire logic uart_one_error_evt, // uart 1 error
  input wire logic pwm_fault_b_evt, // pwm fault b
  input wire logic [15:0] source_flag_0, // flags gated by enable 0
  input wire logic [2:0] source_enable_2, // enables for flag 2 bits
  input wire logic [15:0] source_enable_3, // enables for flag 3
  input wire logic [7:0] source_enable_4, // enables for flag 4
  output logic [2:0] flag_2, // flag 2 bits 2..0
  output logic [15:0] flag_3, // flag 3 contents
  output logic [7:0] flag_4, // flag 4 low byte
  output logic [15:0] enable_0, // enable 0 contents
  output logic [15:0] request_0, // gated enable 0 requests
  output logic [2:0] request_2, // gated flag 2 requests
  output logic [15:0] request_3, // gated flag 3 requests
  output logic [7:0] request_4 // gated flag 4 requests
);

  logic [15:0] interrupt_flag_status_2;
  logic [15:0] interrupt_flag_status_3;
  logic [15:0] interrupt_flag_status_4;
  logic [15:0] interrupt_enable_control_0;
  logic [15:0] events_2;
  logic [15:0] events_3;
  logic [15:0] events_4;
  logic access;
  logic write_strobe;
  logic hit_2;
  logic hit_3;
  logic hit_4;
  logic hit_e0;
  logic [15:0] lane_mask;
  logic [15:0] next_flag_2;
  logic [15:0] next_flag_3;
  logic [15:0] next_flag_4;
  logic [15:0] next_enable_0;
  logic [15:0] next_read;

  // merge a bus write into a register, honouring byte lanes and
  // keeping unimplemented bits at zero
  function automatic logic [15:0] merge_write(
    input logic [15:0] cur,
    input logic [15:0] wdat,
    input logic [15:0] lanes,
    input logic hit,
    input logic [15:0] mask
  );
    logic [15:0] res;
    res = cur;
    if (hit) begin
      res = (cur & ~lanes) | (wdat & lanes);
    end
    merge_write = res & mask;
  endfunction : merge_write

  // event vector of the third flag register
  always_comb begin
    events_2 = 16'h0000;
    events_2[irq_bank_pkg::CAN1_RX_READY_BIT] = can1_rx_ready_evt;
    events_2[irq_bank_pkg::SERIAL_PERIPH2_EVENT_BIT] = serial_periph2_event_evt;
    events_2[irq_bank_pkg::SERIAL_PERIPH2_ERROR_BIT] = serial_periph2_error_evt;
  end

  // event vector of the fourth flag register
  always_comb begin
    events_3 = 16'h0000;
    events_3[irq_bank_pkg::PWM_FAULT_A_BIT] = pwm_fault_a_evt;
    events_3[irq_bank_pkg::DMA_CH5_DONE_BIT] = dma_ch5_done_evt;
    events_3[irq_bank_pkg::CONVERTER_IFACE_EVENT_BIT] = converter_iface_event_evt;
    events_3[irq_bank_pkg::CONVERTER_IFACE_ERROR_BIT] = converter_iface_error_evt;
    events_3[irq_bank_pkg::QUAD_ENCODER_EVENT_BIT] = quad_encoder_event_evt;
    events_3[irq_bank_pkg::PWM_ERROR_BIT] = pwm_error_evt;
    events_3[irq_bank_pkg::CAN2_EVENT_BIT] = can2_event_evt;
    events_3[irq_bank_pkg::CAN2_RX_READY_BIT] = can2_rx_ready_evt;
    events_3[irq_bank_pkg::EXT_PIN4_BIT] = ext_pin4_evt;
    events_3[irq_bank_pkg::EXT_PIN3_BIT] = ext_pin3_evt;
    events_3[irq_bank_pkg::TIMER_NINE_BIT] = timer_nine_evt;
    events_3[irq_bank_pkg::TIMER_EIGHT_BIT] = timer_eight_evt;
    events_3[irq_bank_pkg::I2C_TWO_MASTER_BIT] = i2c_two_master_evt;
    events_3[irq_bank_pkg::I2C_TWO_SLAVE_BIT] = i2c_two_slave_evt;
    events_3[irq_bank_pkg::TIMER_SEVEN_BIT] = timer_seven_evt;
  end

  // event vector of the fifth flag register
  always_comb begin
    events_4 = 16'h0000;
    events_4[irq_bank_pkg::CAN2_TX_REQUEST_BIT] = can2_tx_request_evt;
    events_4[irq_bank_pkg::CAN1_TX_REQUEST_BIT] = can1_tx_request_evt;
    events_4[irq_bank_pkg::DMA_CH7_DONE_BIT] = dma_ch7_done_evt;
    events_4[irq_bank_pkg::DMA_CH6_DONE_BIT] = dma_ch6_done_evt;
    events_4[irq_bank_pkg::UART_TWO_ERROR_BIT] = uart_two_error_evt;
    events_4[irq_bank_pkg::UART_ONE_ERROR_BIT] = uart_one_error_evt;
    events_4[irq_bank_pkg::PWM_FAULT_B_BIT] = pwm_fault_b_evt;
  end

  // address match per register, used by the write decode only, as the
  // read mux decodes wb_adr_i itself; an address outside the four matches none of them
  logic adr_is_2;
  logic adr_is_3;
  logic adr_is_4;
  logic adr_is_e0;
  logic read_strobe;
  logic [15:0] set_2;
  logic [15:0] set_3;
  logic [15:0] set_4;

  // one compare per register offset
  assign adr_is_2 = (wb_adr_i == irq_bank_pkg::FLAG_STATUS_2_OFS);
  assign adr_is_3 = (wb_adr_i == irq_bank_pkg::FLAG_STATUS_3_OFS);
  assign adr_is_4 = (wb_adr_i == irq_bank_pkg::FLAG_STATUS_4_OFS);
  assign adr_is_e0 = (wb_adr_i == irq_bank_pkg::ENABLE_CONTROL_0_OFS);

  // bus decode; a write lands only on the cycle that ack is raised,
  // so a held request writes again only every second cycle; an unmapped write is
  // acknowledged and dropped
  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign write_strobe = access & wb_we_i;
  assign read_strobe = access & ~wb_we_i;
  assign hit_2 = write_strobe & adr_is_2;
  assign hit_3 = write_strobe & adr_is_3;
  assign hit_4 = write_strobe & adr_is_4;
  assign hit_e0 = write_strobe & adr_is_e0;

  // byte lanes 0 and 1 carry the 16-bit registers; lanes 2 and 3
  // are ignored, as the upper half of every word is unimplemented
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // hardware set vectors; unimplemented positions never take an
  // event, so a stray source line cannot make a hole read as 1
  assign set_2 = events_2 & irq_bank_pkg::FLAG_STATUS_2_MASK;
  assign set_3 = events_3 & irq_bank_pkg::FLAG_STATUS_3_MASK;
  assign set_4 = events_4 & irq_bank_pkg::FLAG_STATUS_4_MASK;

  // third flag register next value: an event ORs in after the write,
  // so a set that meets a software clear in the same cycle wins
  always_comb begin
    next_flag_2 = merge_write(interrupt_flag_status_2, wb_dat_i[15:0], lane_mask, hit_2,
                              irq_bank_pkg::FLAG_STATUS_2_MASK) | set_2;
  end

  // fourth flag register next value, with the same set-wins order;
  // bit 14 is masked on both paths so it can never stick
  always_comb begin
    next_flag_3 = merge_write(interrupt_flag_status_3, wb_dat_i[15:0], lane_mask, hit_3,
                              irq_bank_pkg::FLAG_STATUS_3_MASK) | set_3;
  end

  // fifth flag register next value, with the same set-wins order;
  // the upper byte and bit 3 are masked on both paths
  always_comb begin
    next_flag_4 = merge_write(interrupt_flag_status_4, wb_dat_i[15:0], lane_mask, hit_4,
                              irq_bank_pkg::FLAG_STATUS_4_MASK) | set_4;
  end

  // enable register next value; only software moves an enable bit,
  // so there is no event path here
  always_comb begin
    next_enable_0 = merge_write(interrupt_enable_control_0, wb_dat_i[15:0], lane_mask, hit_e0,
                                irq_bank_pkg::ENABLE_CONTROL_0_MASK);
  end

  // third flag register; cleared at power-on, and events seen
  // during reset are dropped rather than remembered
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      interrupt_flag_status_2 <= irq_bank_pkg::FLAG_RESET;
    end else begin
      interrupt_flag_status_2 <= next_flag_2;
    end
  end

  // fourth flag register, cleared at power-on; events during
  // reset are dropped as well
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      interrupt_flag_status_3 <= irq_bank_pkg::FLAG_RESET;
    end else begin
      interrupt_flag_status_3 <= next_flag_3;
    end
  end

  // fifth flag register, cleared at power-on; events during
  // reset are dropped as well
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      interrupt_flag_status_4 <= irq_bank_pkg::FLAG_RESET;
    end else begin
      interrupt_flag_status_4 <= next_flag_4;
    end
  end

  // enable register, cleared at power-on so that no source_flag_0 flag
  // can reach the processor on request_0 before software has set it up
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      interrupt_enable_control_0 <= irq_bank_pkg::ENABLE_RESET;
    end else begin
      interrupt_enable_control_0 <= next_enable_0;
    end
  end

  // read mux; unmapped addresses read zero rather than erroring,
  // which keeps simple masters from hanging on a bad pointer;
  // the registers already hold zero in every unimplemented place
  always_comb begin
    case (wb_adr_i)
      irq_bank_pkg::FLAG_STATUS_2_OFS: begin
        next_read = interrupt_flag_status_2;
      end
      irq_bank_pkg::FLAG_STATUS_3_OFS: begin
        next_read = interrupt_flag_status_3;
      end
      irq_bank_pkg::FLAG_STATUS_4_OFS: begin
        next_read = interrupt_flag_status_4;
      end
      irq_bank_pkg::ENABLE_CONTROL_0_OFS: begin
        next_read = interrupt_enable_control_0;
      end
      default: begin
        next_read = 16'h0000;
      end
    endcase
  end

  // single-wait acknowledge, dropped the cycle after it was given;
  // a master that keeps stb up gets a new access every second
  // cycle, which is the price of registering ack
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // read data registered alongside ack and held until the next
  // read; writes leave it alone, so a late sampler still sees
  // the last read value; the upper half is always zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wb_dat_o <= 32'h00000000;
    end else if (read_strobe) begin
      wb_dat_o <= {16'h0000, next_read};
    end
  end

  // flag contents towards the rest of the controller; only the
  // implemented low bits of the third and fifth registers leave
  assign flag_2 = interrupt_flag_status_2[2:0];
  assign flag_3 = interrupt_flag_status_3;
  assign flag_4 = interrupt_flag_status_4[7:0];

  // enable contents towards the flags that are held outside this
  // bank, straight from the flip-flops
  assign enable_0 = interrupt_enable_control_0;

  // enable-gated requests for the flags held outside; registered so
  // the processor side sees glitch-free levels, at one cycle of latency
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      request_0 <= 16'h0000;
    end else begin
      request_0 <= source_flag_0 & next_enable_0;
    end
  end

  // flag-gated requests of the third flag register; taken from the
  // next flag value so a request follows its flag on the same edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      request_2 <= 3'h0;
    end else begin
      request_2 <= next_flag_2[2:0] & source_enable_2;
    end
  end

  // flag-gated requests of the fourth flag register, with the
  // enables held outside this bank
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      request_3 <= 16'h0000;
    end else begin
      request_3 <= next_flag_3 & source_enable_3;
    end
  end

  // flag-gated requests of the fifth flag register, with the
  // enables held outside this bank
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      request_4 <= 8'h00;
    end else begin
      request_4 <= next_flag_4[7:0] & source_enable_4;
    end
  end

endmodule : interrupt_flag_enable_bank

// >>> irq_bank_pkg.sv
package irq_bank_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] FLAG_STATUS_2_OFS = 8'h00;
  localparam logic [7:0] FLAG_STATUS_3_OFS = 8'h04;
  localparam logic [7:0] FLAG_STATUS_4_OFS = 8'h08;
  localparam logic [7:0] ENABLE_CONTROL_0_OFS = 8'h0C;

  // implemented bits of each register
  localparam logic [15:0] FLAG_STATUS_2_MASK = 16'h0007;
  localparam logic [15:0] FLAG_STATUS_3_MASK = 16'hBFFF;
  localparam logic [15:0] FLAG_STATUS_4_MASK = 16'h00F7;
  localparam logic [15:0] ENABLE_CONTROL_0_MASK = 16'h7FFF;

  // power-on values
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;

  // third flag register, low bits
  localparam int CAN1_RX_READY_BIT = 2;
  localparam int SERIAL_PERIPH2_EVENT_BIT = 1;
  localparam int SERIAL_PERIPH2_ERROR_BIT = 0;

  // fourth flag register
  localparam int PWM_FAULT_A_BIT = 15;
  localparam int DMA_CH5_DONE_BIT = 13;
  localparam int CONVERTER_IFACE_EVENT_BIT = 12;
  localparam int CONVERTER_IFACE_ERROR_BIT = 11;
  localparam int QUAD_ENCODER_EVENT_BIT = 10;
  localparam int PWM_ERROR_BIT = 9;
  localparam int CAN2_EVENT_BIT = 8;
  localparam int CAN2_RX_READY_BIT = 7;
  localparam int EXT_PIN4_BIT = 6;
  localparam int EXT_PIN3_BIT = 5;
  localparam int TIMER_NINE_BIT = 4;
  localparam int TIMER_EIGHT_BIT = 3;
  localparam int I2C_TWO_MASTER_BIT = 2;
  localparam int I2C_TWO_SLAVE_BIT = 1;
  localparam int TIMER_SEVEN_BIT = 0;

  // fifth flag register
  localparam int CAN2_TX_REQUEST_BIT = 7;
  localparam int CAN1_TX_REQUEST_BIT = 6;
  localparam int DMA_CH7_DONE_BIT = 5;
  localparam int DMA_CH6_DONE_BIT = 4;
  localparam int UART_TWO_ERROR_BIT = 2;
  localparam int UART_ONE_ERROR_BIT = 1;
  localparam int PWM_FAULT_B_BIT = 0;

endpackage : irq_bank_pkg

// >>> irq_bank_properties.sv
`timescale 1ns/10ps
module irq_bank_checker (
  input wire logic sys_clk, // system clock
  input wire logic reset, // sync reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write when high
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic timer_seven_evt, // one watched source
  input wire logic [15:0] flag_3, // flag register contents
  input wire logic [15:0] enable_0, // enable register contents
  input wire logic [15:0] source_enable_3, // outside enables
  input wire logic [15:0] source_flag_0, // outside flags
  input wire logic [15:0] request_3, // gated flag requests
  input wire logic [15:0] request_0 // gated enable requests
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // a request is only new while ack is low; a held strobe makes a new access every second cycle
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence en0_write;
    bus_req ##0 (wb_we_i && wb_adr_i == irq_bank_pkg::ENABLE_CONTROL_0_OFS && wb_sel_i[1:0] == 2'b11);
  endsequence

  chk_ack_after_req: assert property (bus_req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_unimpl_zero: assert property (!flag_3[14] && !enable_0[15])
    else $error("unimplemented bit set");
  chk_event_sets: assert property (timer_seven_evt |=> flag_3[0])
    else $error("event did not set its flag");
  chk_flag_sticky: assert property (flag_3[0] && !wb_cyc_i |=> flag_3[0])
    else $error("flag dropped without a write");
  chk_enable_write: assert property (en0_write |=> enable_0 == ($past(wb_dat_i[15:0]) & irq_bank_pkg::ENABLE_CONTROL_0_MASK))
    else $error("enable write not stored");
  chk_gate_flag: assert property (##1 request_3 == (flag_3 & $past(source_enable_3)))
    else $error("flag request not gated");
  chk_gate_enable: assert property (request_0 == ($past(source_flag_0) & enable_0))
    else $error("enable request not gated");
  chk_reset_clears: assert property (disable iff (1'b0) reset |=> !wb_ack_o && flag_3 == 16'h0000 && enable_0 == 16'h0000)
    else $error("reset left state behind");
endmodule : irq_bank_checker

bind interrupt_flag_enable_bank irq_bank_checker i_irq_bank_checker (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_seven_evt, .flag_3, .enable_0,
  .source_enable_3, .source_flag_0, .request_3, .request_0);

// >>> irq_source_model.sv
`timescale 1ns/10ps
module irq_source_model (
  input wire logic sys_clk, // system clock
  input wire logic reset, // sync reset
  input wire logic fire, // launch one pulse
  input wire logic [31:0] pattern, // sources to pulse
  output logic [26:0] events // one bit per source
);
  // quiet unless fired; a held fire would look like a stuck source
  always_ff @(posedge sys_clk) begin
    if (reset || !fire) begin
      events <= 27'h0000000;
    end else begin
      events <= pattern[26:0];
    end
  end
endmodule : irq_source_model

// >>> interrupt_flag_enable_bank_tb.sv
`timescale 1ns/10ps
module interrupt_flag_enable_bank_tb;
  logic sys_clk, reset, wb_cyc, wb_stb, wb_we, fire, wb_ack_o;
  logic [3:0] wb_sel, s;
  logic [7:0] wb_adr, source_enable_4, flag_4, request_4;
  logic [2:0] source_enable_2, flag_2, request_2;
  logic [15:0] source_flag_0, source_enable_3, flag_3, enable_0, request_0, request_3;
  logic [15:0] sh [5];
  logic [31:0] wb_dat, wb_dat_o, rd_dat, pattern, d;
  logic [26:0] ev;
  int num_errors = 0;
  int checks = 0;
  int seed;
  logic [7:0] adrs [5] = '{irq_bank_pkg::FLAG_STATUS_2_OFS, irq_bank_pkg::FLAG_STATUS_3_OFS,
    irq_bank_pkg::FLAG_STATUS_4_OFS, irq_bank_pkg::ENABLE_CONTROL_0_OFS, 8'h10};
  logic [15:0] masks [5] = '{irq_bank_pkg::FLAG_STATUS_2_MASK, irq_bank_pkg::FLAG_STATUS_3_MASK,
    irq_bank_pkg::FLAG_STATUS_4_MASK, irq_bank_pkg::ENABLE_CONTROL_0_MASK, 16'h0000};

  always #2.5 sys_clk = ~sys_clk;

  irq_source_model i_irq_source_model (.sys_clk, .reset, .fire, .pattern, .events(ev));
  // event vector: bits 2:0 third flag, 18:3 fourth flag, 26:19 fifth flag
  interrupt_flag_enable_bank i_interrupt_flag_enable_bank (.sys_clk, .reset, .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o,
    .wb_ack_o, .can1_rx_ready_evt(ev[2]), .serial_periph2_event_evt(ev[1]), .serial_periph2_error_evt(ev[0]),
    .pwm_fault_a_evt(ev[18]), .dma_ch5_done_evt(ev[16]), .converter_iface_event_evt(ev[15]),
    .converter_iface_error_evt(ev[14]), .quad_encoder_event_evt(ev[13]), .pwm_error_evt(ev[12]),
    .can2_event_evt(ev[11]), .can2_rx_ready_evt(ev[10]), .ext_pin4_evt(ev[9]), .ext_pin3_evt(ev[8]),
    .timer_nine_evt(ev[7]), .timer_eight_evt(ev[6]), .i2c_two_master_evt(ev[5]), .i2c_two_slave_evt(ev[4]),
    .timer_seven_evt(ev[3]), .can2_tx_request_evt(ev[26]), .can1_tx_request_evt(ev[25]),
    .dma_ch7_done_evt(ev[24]), .dma_ch6_done_evt(ev[23]), .uart_two_error_evt(ev[21]),
    .uart_one_error_evt(ev[20]), .pwm_fault_b_evt(ev[19]), .source_flag_0, .source_enable_2, .source_enable_3,
    .source_enable_4, .flag_2, .flag_3, .flag_4, .enable_0, .request_0, .request_2, .request_3, .request_4);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // held until the ack edge, read data taken there, released after it
  task automatic wb_access(input logic we, input int i, input logic [31:0] dat, input logic [3:0] sel);
    int n = 0;
    {wb_cyc, wb_stb, wb_we} <= {2'b11, we};
    {wb_adr, wb_sel, wb_dat} <= {adrs[i], sel, dat};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      stop_test();
    end
    rd_dat = wb_dat_o;
    {wb_cyc, wb_stb} <= 2'b00;
    @(posedge sys_clk);
  endtask : wb_access

  // lanes written independently; unimplemented bits never stick
  function automatic logic [15:0] after_write(logic [15:0] old, logic [31:0] dat, logic [3:0] sel, logic [15:0] m);
    logic [15:0] lanes;
    lanes = {{8{sel[1]}}, {8{sel[0]}}};
    return ((old & ~lanes) | (dat[15:0] & lanes)) & m;
  endfunction : after_write

  task automatic read_all_zero();
    for (int i = 0; i < 5; i++) begin
      wb_access(1'b0, i, 32'h00000000, 4'hF);
      cmp(rd_dat, 32'h00000000);
      sh[i] = 16'h0000;
    end
    cmp({5'h00, flag_2, flag_4, flag_3}, 32'h00000000);
    cmp({5'h00, request_2, request_4, request_3}, 32'h00000000);
    cmp({16'h0000, request_0}, 32'h00000000);
  endtask : read_all_zero

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    {wb_cyc, wb_stb, wb_we, fire, wb_adr, wb_sel, wb_dat, pattern} = 80'h0;
    {source_flag_0, source_enable_2, source_enable_3, source_enable_4} = 43'h0;
    seed = $urandom(26);
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    read_all_zero();
    $display("test reset values done");
    // first pass writes all ones, then random data and lanes, unmapped place included
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 5; i++) begin
        d = (k == 0) ? 32'hFFFFFFFF : $urandom;
        s = (k == 0) ? 4'hF : 4'($urandom);
        wb_access(1'b1, i, d, s);
        sh[i] = after_write(sh[i], d, s, masks[i]);
        wb_access(1'b0, i, 32'h00000000, 4'hF);
        cmp(rd_dat, {16'h0000, sh[i]});
      end
    end
    cmp({16'h0000, enable_0}, {16'h0000, sh[3]});
    $display("test register access done");
    // corner: a clearing write meets every event in one cycle; the set wins
    for (int i = 0; i < 3; i++) begin
      pattern <= 32'hFFFFFFFF;
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      wb_access(1'b1, i, 32'h00000000, 4'hF);
      wb_access(1'b0, i, 32'h00000000, 4'hF);
      cmp(rd_dat, {16'h0000, masks[i]});
    end
    for (int i = 0; i < 3; i++) sh[i] = masks[i];
    $display("test set wins done");
    // random source pulses with random gating; flags rewritten with random data every fourth pass
    for (int k = 0; k < 60; k++) begin
      pattern <= $urandom;
      source_flag_0 <= $urandom;
      {source_enable_2, source_enable_3, source_enable_4} <= 27'($urandom);
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      repeat (3) @(posedge sys_clk);
      sh[0] |= {13'h0000, pattern[2:0]};
      sh[1] |= pattern[18:3] & masks[1];
      sh[2] |= {8'h00, pattern[26:19]} & masks[2];
      for (int i = 0; i < 3; i++) begin
        wb_access(1'b0, i, 32'h00000000, 4'hF);
        cmp(rd_dat, {16'h0000, sh[i]});
      end
      cmp({5'h00, flag_2, flag_4, flag_3}, {5'h00, sh[0][2:0], sh[2][7:0], sh[1]});
      cmp({5'h00, request_2, request_4, request_3},
        {5'h00, sh[0][2:0] & source_enable_2, sh[2][7:0] & source_enable_4, sh[1] & source_enable_3});
      cmp({16'h0000, request_0}, {16'h0000, source_flag_0 & sh[3]});
      for (int i = 0; i < 3 && k[1:0] == 2'b11; i++) begin
        d = $urandom;
        wb_access(1'b1, i, d, 4'hF);
        sh[i] = after_write(sh[i], d, 4'hF, masks[i]);
      end
    end
    $display("test source events done");
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    read_all_zero();
    $display("test second reset done");
    stop_test();
  end
endmodule : interrupt_flag_enable_bank_tb
